// File: inc/frs_pkg.sv
// Purpose: Shared constants, codes and state layout of the frequency reference selector.
// Assumes: Frequencies are signed counts in the resolution chosen by software.
// Notes: Register offsets are byte addresses on a 32-bit APB bus.
// Operation
// RULE1 - Units 0: target is main source X
// RULE2 - Units 1: target is the combined result
// RULE3 - Units 2: switch terminal picks X or Y
// RULE4 - Units 3: switch terminal picks X or combined
// RULE5 - Units 4: switch terminal picks Y or combined
// RULE6 - Tens 0: combined is X plus Y
// RULE7 - Tens 1: combined is X minus Y
// RULE8 - Tens 2: larger absolute value of both
// RULE9 - Tens 3: smaller absolute value of both
// RULE10 - Offset added only when combined result selected
// RULE11 - Upper limit source chosen by code
// RULE12 - Full-scale analog equals digital upper limit
// RULE13 - Analog or pulse upper limit gets offset
// RULE14 - Ramp time unit 1s, 0.1s, 0.01s
// RULE15 - Unit change reinterprets all four time sets
// RULE16 - Ramp base: maximum, set, or 100Hz
// RULE17 - Up/down base mode for digital sources
// RULE18 - Resolution code 1 or 2, default 2
// RULE19 - Coarse resolution allows up to 3200.0Hz
// RULE20 - Aux range may scale relative to X
// RULE21 - Target registered one cycle after changes
`default_nettype none
package frs_pkg;
  // Frequency word width; a sign bit plus room for 3200.0Hz and 655.35Hz.
  localparam int FRS_FW = 18;
  typedef logic signed [FRS_FW-1:0] frs_freq_t;
  // Register byte offsets.
  localparam logic [7:0] FRS_OFS_COMBO = 8'h00;
  localparam logic [7:0] FRS_OFS_OFFSET = 8'h04;
  localparam logic [7:0] FRS_OFS_UPCFG = 8'h08;
  localparam logic [7:0] FRS_OFS_UPDIG = 8'h0C;
  localparam logic [7:0] FRS_OFS_UPOFS = 8'h10;
  localparam logic [7:0] FRS_OFS_RAMP = 8'h14;
  localparam logic [7:0] FRS_OFS_MAXF = 8'h18;
  localparam logic [7:0] FRS_OFS_AUXPCT = 8'h1C;
  localparam logic [7:0] FRS_OFS_TARGET = 8'h20;
  localparam logic [7:0] FRS_OFS_UPPER = 8'h24;
  localparam logic [7:0] FRS_OFS_BASE = 8'h28;
  localparam logic [7:0] FRS_OFS_TIME0 = 8'h30;
  // Field positions.
  localparam int FRS_UNITS_LSB = 0;
  localparam int FRS_TENS_LSB = 4;
  localparam int FRS_AUXREF_BIT = 8;
  localparam int FRS_TUNIT_LSB = 0;
  localparam int FRS_TBASE_LSB = 4;
  localparam int FRS_UDMODE_LSB = 8;
  localparam int FRS_RES_LSB = 12;
  // Reset values.
  localparam logic [2:0] FRS_UNITS_RST = 3'h0;
  localparam logic [1:0] FRS_TENS_RST = 2'h0;
  localparam logic [7:0] FRS_AUXPCT_RST = 8'h64;
  localparam logic [1:0] FRS_TUNIT_RST = 2'h1;
  localparam logic [1:0] FRS_TBASE_RST = 2'h0;
  localparam logic [1:0] FRS_UDMODE_RST = 2'h1;
  localparam logic [1:0] FRS_RES_RST = 2'h2;
  localparam frs_freq_t FRS_MAXF_RST = 18'h01388;
  // Codes.
  localparam logic [2:0] FRS_U_X = 3'h0;
  localparam logic [2:0] FRS_U_COMB = 3'h1;
  localparam logic [2:0] FRS_U_XY = 3'h2;
  localparam logic [2:0] FRS_U_XC = 3'h3;
  localparam logic [2:0] FRS_U_YC = 3'h4;
  localparam logic [2:0] FRS_UP_DIG = 3'h0;
  localparam logic [2:0] FRS_UP_AN1 = 3'h1;
  localparam logic [2:0] FRS_UP_AN2 = 3'h2;
  localparam logic [2:0] FRS_UP_PULSE = 3'h4;
  localparam logic [2:0] FRS_UP_COMM = 3'h5;
  localparam logic [1:0] FRS_RES_COARSE = 2'h1;
  // Frequency caps and the fixed 100Hz base in each resolution, then the 100 percent full aux range.
  localparam frs_freq_t FRS_CAP_COARSE = 18'h07D00;
  localparam frs_freq_t FRS_CAP_FINE = 18'h0FFFF;
  localparam frs_freq_t FRS_B100_COARSE = 18'h003E8;
  localparam frs_freq_t FRS_B100_FINE = 18'h02710;
  localparam logic [7:0] FRS_PCT_FULL = 8'h64;
  // Time multipliers to 0.01s units for unit codes 0, 1 and 2.
  localparam logic [7:0] FRS_TMUL_1S = 8'h64;
  localparam logic [7:0] FRS_TMUL_01S = 8'h0A;
  localparam logic [7:0] FRS_TMUL_001S = 8'h01;
  // Whole state of the selector.
  typedef struct packed {
    logic [2:0] units;
    logic [1:0] tens;
    logic aux_ref;
    logic [7:0] aux_pct;
    frs_freq_t ofs;
    logic [2:0] up_src;
    frs_freq_t up_dig;
    frs_freq_t up_ofs;
    logic [1:0] t_unit;
    logic [1:0] t_base;
    logic [1:0] ud_mode;
    logic [1:0] res;
    frs_freq_t max_f;
    logic [3:0][15:0] acc_t;
    frs_freq_t ud;
    logic [1:0] sw_s;
    logic [1:0] up_s;
    logic [1:0] dn_s;
    logic up_prev;
    logic dn_prev;
    frs_freq_t target;
    frs_freq_t upper;
    frs_freq_t base;
    logic [23:0] ramp_t;
    logic [31:0] rdata;
    logic slverr;
  } frs_state_t;
endpackage
`default_nettype wire

// File: verilog/frs_selector.sv
// Purpose: Forms target frequency, upper limit and ramp settings from X, Y and settings.
// Assumes: X, Y and input values come from logic on pclk; terminal pins are asynchronous.
// Notes: APB slave with zero wait states; read data is captured in the setup cycle.
//
// Local design decisions: register access over APB and the address map.
`default_nettype none
module frs_selector #(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire frs_pkg::frs_freq_t x_in,
  input wire frs_pkg::frs_freq_t y_in,
  input wire logic x_is_digital,
  input wire logic running,
  input wire frs_pkg::frs_freq_t run_freq,
  input wire logic freq_switch_pin,
  input wire logic up_pin,
  input wire logic down_pin,
  input wire logic [AW-1:0] analog_input_one,
  input wire logic [AW-1:0] analog_input_two_or_current,
  input wire frs_pkg::frs_freq_t pulse_upper,
  input wire frs_pkg::frs_freq_t comm_upper,
  input wire logic [1:0] ramp_set_sel,
  output frs_pkg::frs_freq_t target_freq,
  output frs_pkg::frs_freq_t upper_limit,
  output frs_pkg::frs_freq_t ramp_base_freq,
  output logic [23:0] ramp_time_cs,
  output logic [1:0] freq_decimals
);
  import frs_pkg::*;

  // Full-scale analog code that stands for 100 percent.
  localparam logic [AW-1:0] AN_FULL = {AW{1'b1}};

  frs_state_t s_q; // Registered state.
  frs_state_t s_d; // Next state.

  // Wide signed helpers for the arithmetic; sized so no product overflows.
  logic signed [47:0] x_eff; // Main source with up/down adjustment.
  logic signed [47:0] y_rng; // Auxiliary source after range scaling.
  logic signed [47:0] comb; // Combined X/Y result plus offset.
  logic signed [47:0] sel; // Selected source before clamping.
  logic signed [47:0] cap; // Resolution cap.
  logic signed [47:0] up_w; // Upper limit before clamping.
  logic signed [47:0] ax; // Absolute value of X.
  logic signed [47:0] ay; // Absolute value of Y.
  logic [AW-1:0] an_sel; // Analog channel used for the upper limit.
  logic comb_used; // Combined result is the current pick.
  logic wr_acc; // APB write access phase.
  logic rd_setup; // APB read setup cycle.
  logic up_ev; // Synchronised rising edge of the up terminal.
  logic dn_ev; // Synchronised rising edge of the down terminal.
  logic [7:0] tmul; // Time multiplier for the chosen unit.

  // Saturate a wide value into plus or minus the limit.
  function automatic logic signed [47:0] frs_sat(input logic signed [47:0] v,
                                                 input logic signed [47:0] lim);
    logic signed [47:0] r;
    r = v;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return r;
  endfunction

  // Next-state logic: bus, synchronisers, and all frequency arithmetic.
  always_comb begin
    s_d = s_q;
    wr_acc = psel && penable && pwrite;
    rd_setup = psel && !penable && !pwrite;
    // Two-flop synchronisers; only the second stage is used below.
    s_d.sw_s = {s_q.sw_s[0], freq_switch_pin};
    s_d.up_s = {s_q.up_s[0], up_pin};
    s_d.dn_s = {s_q.dn_s[0], down_pin};
    s_d.up_prev = s_q.up_s[1];
    s_d.dn_prev = s_q.dn_s[1];
    up_ev = s_q.up_s[1] && !s_q.up_prev;
    dn_ev = s_q.dn_s[1] && !s_q.dn_prev;

    // Up/down adjustment only applies to a digitally set main source.
    if (!x_is_digital) begin
      s_d.ud = '0; // RULE17
    end else if (s_q.ud_mode == 2'h3 && !running) begin
      s_d.ud = '0; // RULE17
    end else if (s_q.ud_mode == 2'h2 && !running) begin
      s_d.ud = s_q.ud; // RULE17
    end else if (up_ev != dn_ev) begin
      // Mode 0 rebases on the running frequency, so a press during a ramp can jump.
      if (s_q.ud_mode == 2'h0) begin
        s_d.ud = run_freq - x_in + (up_ev ? 18'sh00001 : -18'sh00001); // RULE17
      end else begin
        s_d.ud = s_q.ud + (up_ev ? 18'sh00001 : -18'sh00001); // RULE17
      end
    end
    x_eff = 48'(x_in) + (x_is_digital ? 48'(s_q.ud) : 48'sh0);

    // Auxiliary range: relative to maximum or to X, then scaled by percent.
    if (s_q.aux_ref && s_q.max_f != '0) begin
      y_rng = (48'(y_in) * x_eff) / 48'(s_q.max_f); // RULE20
    end else begin
      y_rng = 48'(y_in);
    end
    y_rng = (y_rng * $signed({40'h0, s_q.aux_pct})) / $signed({40'h0, FRS_PCT_FULL});
    ax = (x_eff < 0) ? -x_eff : x_eff;
    ay = (y_rng < 0) ? -y_rng : y_rng;

    // Arithmetic combination chosen by the tens digit.
    unique case (s_q.tens)
      2'h0: comb = x_eff + y_rng; // RULE6
      2'h1: comb = x_eff - y_rng; // RULE7
      2'h2: comb = (ax >= ay) ? x_eff : y_rng; // RULE8
      2'h3: comb = (ax <= ay) ? x_eff : y_rng; // RULE9
    endcase
    comb = comb + 48'(s_q.ofs); // RULE10

    // Source pick chosen by the units digit and the switch terminal.
    comb_used = 1'b0;
    sel = x_eff;
    unique case (s_q.units)
      FRS_U_X: sel = x_eff; // RULE1
      FRS_U_COMB: comb_used = 1'b1; // RULE2
      FRS_U_XY: sel = s_q.sw_s[1] ? 48'(y_in) : x_eff; // RULE3
      FRS_U_XC: comb_used = s_q.sw_s[1]; // RULE4
      FRS_U_YC: begin
        comb_used = s_q.sw_s[1]; // RULE5
        sel = 48'(y_in);
      end
      default: sel = x_eff;
    endcase
    if (comb_used) begin
      sel = comb; // RULE10
    end

    // Resolution cap; coarse resolution reaches 3200.0Hz.
    cap = (s_q.res == FRS_RES_COARSE) ? 48'(FRS_CAP_COARSE) : 48'(FRS_CAP_FINE); // RULE19

    // Upper limit source; analog full scale stands for the digital setting.
    an_sel = (s_q.up_src == FRS_UP_AN2) ? analog_input_two_or_current : analog_input_one;
    unique case (s_q.up_src)
      FRS_UP_AN1, FRS_UP_AN2: begin
        up_w = (48'(s_q.up_dig) * $signed({{(48-AW){1'b0}}, an_sel}))
               / $signed({{(48-AW){1'b0}}, AN_FULL}); // RULE12
        up_w = up_w + 48'(s_q.up_ofs); // RULE13
      end
      FRS_UP_PULSE: up_w = 48'(pulse_upper) + 48'(s_q.up_ofs); // RULE13
      FRS_UP_COMM: up_w = 48'(comm_upper); // RULE11
      default: up_w = 48'(s_q.up_dig); // RULE11
    endcase
    up_w = frs_sat(up_w, cap);
    if (up_w < 0) begin
      up_w = '0;
    end
    s_d.upper = FRS_FW'(up_w);

    // Target is clamped to the upper limit and registered.
    s_d.target = FRS_FW'(frs_sat(sel, up_w)); // RULE21

    // Ramp base frequency.
    unique case (s_q.t_base)
      2'h1: s_d.base = s_q.target; // RULE16
      2'h2: s_d.base = (s_q.res == FRS_RES_COARSE) ? FRS_B100_COARSE : FRS_B100_FINE; // RULE16
      default: s_d.base = s_q.max_f; // RULE16
    endcase

    // Stored time values are reinterpreted by the unit, never rewritten.
    unique case (s_q.t_unit)
      2'h0: tmul = FRS_TMUL_1S; // RULE14
      2'h2: tmul = FRS_TMUL_001S; // RULE14
      default: tmul = FRS_TMUL_01S; // RULE14
    endcase
    s_d.ramp_t = s_q.acc_t[ramp_set_sel] * tmul; // RULE15

    // Register writes take effect in the access phase.
    s_d.slverr = 1'b0;
    if (wr_acc) begin
      unique case (paddr)
        FRS_OFS_COMBO: begin
          s_d.units = pwdata[FRS_UNITS_LSB +: 3];
          s_d.tens = pwdata[FRS_TENS_LSB +: 2];
          s_d.aux_ref = pwdata[FRS_AUXREF_BIT];
        end
        FRS_OFS_OFFSET: s_d.ofs = pwdata[FRS_FW-1:0];
        FRS_OFS_UPCFG: s_d.up_src = pwdata[2:0];
        FRS_OFS_UPDIG: s_d.up_dig = pwdata[FRS_FW-1:0];
        FRS_OFS_UPOFS: s_d.up_ofs = pwdata[FRS_FW-1:0];
        FRS_OFS_RAMP: begin
          s_d.t_unit = pwdata[FRS_TUNIT_LSB +: 2];
          s_d.t_base = pwdata[FRS_TBASE_LSB +: 2];
          s_d.ud_mode = pwdata[FRS_UDMODE_LSB +: 2];
          // Only codes 1 and 2 are legal; others leave resolution alone.
          if (pwdata[FRS_RES_LSB +: 2] == 2'h1 || pwdata[FRS_RES_LSB +: 2] == 2'h2) begin
            s_d.res = pwdata[FRS_RES_LSB +: 2]; // RULE18
          end
        end
        FRS_OFS_MAXF: s_d.max_f = pwdata[FRS_FW-1:0];
        FRS_OFS_AUXPCT: s_d.aux_pct = pwdata[7:0];
        FRS_OFS_TIME0: s_d.acc_t[0] = pwdata[15:0];
        FRS_OFS_TIME0 + 8'h04: s_d.acc_t[1] = pwdata[15:0];
        FRS_OFS_TIME0 + 8'h08: s_d.acc_t[2] = pwdata[15:0];
        FRS_OFS_TIME0 + 8'h0C: s_d.acc_t[3] = pwdata[15:0];
        FRS_OFS_TARGET, FRS_OFS_UPPER, FRS_OFS_BASE: s_d.slverr = 1'b0;
        default: s_d.slverr = 1'b0;
      endcase
    end

    // Read data and error flag are captured in the setup cycle.
    if (psel && !penable) begin
      s_d.rdata = '0;
      s_d.slverr = 1'b0;
      unique case (paddr)
        FRS_OFS_COMBO: begin
          s_d.rdata[FRS_UNITS_LSB +: 3] = s_q.units;
          s_d.rdata[FRS_TENS_LSB +: 2] = s_q.tens;
          s_d.rdata[FRS_AUXREF_BIT] = s_q.aux_ref;
        end
        FRS_OFS_OFFSET: s_d.rdata[FRS_FW-1:0] = s_q.ofs;
        FRS_OFS_UPCFG: s_d.rdata[2:0] = s_q.up_src;
        FRS_OFS_UPDIG: s_d.rdata[FRS_FW-1:0] = s_q.up_dig;
        FRS_OFS_UPOFS: s_d.rdata[FRS_FW-1:0] = s_q.up_ofs;
        FRS_OFS_RAMP: begin
          s_d.rdata[FRS_TUNIT_LSB +: 2] = s_q.t_unit;
          s_d.rdata[FRS_TBASE_LSB +: 2] = s_q.t_base;
          s_d.rdata[FRS_UDMODE_LSB +: 2] = s_q.ud_mode;
          s_d.rdata[FRS_RES_LSB +: 2] = s_q.res;
        end
        FRS_OFS_MAXF: s_d.rdata[FRS_FW-1:0] = s_q.max_f;
        FRS_OFS_AUXPCT: s_d.rdata[7:0] = s_q.aux_pct;
        // Only the frequency bits are returned; upper bits read zero like every field.
        FRS_OFS_TARGET: s_d.rdata[FRS_FW-1:0] = s_q.target;
        FRS_OFS_UPPER: s_d.rdata[FRS_FW-1:0] = s_q.upper;
        FRS_OFS_BASE: s_d.rdata[FRS_FW-1:0] = s_q.base;
        FRS_OFS_TIME0: s_d.rdata[15:0] = s_q.acc_t[0];
        FRS_OFS_TIME0 + 8'h04: s_d.rdata[15:0] = s_q.acc_t[1];
        FRS_OFS_TIME0 + 8'h08: s_d.rdata[15:0] = s_q.acc_t[2];
        FRS_OFS_TIME0 + 8'h0C: s_d.rdata[15:0] = s_q.acc_t[3];
        // Unmapped addresses answer with an error and zero data.
        default: s_d.slverr = 1'b1;
      endcase
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.units <= FRS_UNITS_RST;
      s_q.tens <= FRS_TENS_RST;
      s_q.aux_pct <= FRS_AUXPCT_RST;
      s_q.t_unit <= FRS_TUNIT_RST; // RULE14
      s_q.t_base <= FRS_TBASE_RST;
      s_q.ud_mode <= FRS_UDMODE_RST;
      s_q.res <= FRS_RES_RST; // RULE18
      s_q.max_f <= FRS_MAXF_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; pready is combinational, data comes from flip-flops.
  assign pready = psel && penable;
  assign pslverr = psel && penable && s_q.slverr;
  assign prdata = s_q.rdata;
  assign target_freq = s_q.target;
  assign upper_limit = s_q.upper;
  assign ramp_base_freq = s_q.base;
  assign ramp_time_cs = s_q.ramp_t;
  assign freq_decimals = s_q.res; // RULE18

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Helpers for the assertions.
  logic asrt_sw; // Settled switch level.
  assign asrt_sw = s_q.sw_s[1];

  a_units_zero_x: assert property ((s_q.units == FRS_U_X && !x_is_digital && 48'(x_in) <= up_w
      && -48'(x_in) <= up_w) |=> target_freq == $past(x_in)) // RULE1
    else $error("Units 0 target not X.");
  a_units_comb: assert property (s_q.units == FRS_U_COMB |-> comb_used) // RULE2
    else $error("Units 1 did not use combined result.");
  a_switch_xy: assert property ((s_q.units == FRS_U_XY && asrt_sw) |-> sel == 48'(y_in)) // RULE3
    else $error("Switch active did not pick Y.");
  a_switch_xc: assert property ((s_q.units == FRS_U_XC && !asrt_sw) |-> !comb_used) // RULE4
    else $error("Switch inactive still picked combined.");
  a_switch_yc: assert property ((s_q.units == FRS_U_YC) |-> comb_used == asrt_sw) // RULE5
    else $error("Units 4 pick wrong.");
  a_tens_sum: assert property ((s_q.tens == 2'h0) |-> comb == x_eff + y_rng + 48'(s_q.ofs)) // RULE6
    else $error("Sum combination wrong.");
  a_tens_diff: assert property ((s_q.tens == 2'h1) |-> comb == x_eff - y_rng + 48'(s_q.ofs)) // RULE7
    else $error("Difference combination wrong.");
  a_res_cap: assert property (s_q.res == FRS_RES_COARSE |=> upper_limit <= FRS_CAP_COARSE) // RULE19
    else $error("Coarse resolution cap exceeded.");
  a_res_legal: assert property (freq_decimals == 2'h1 || freq_decimals == 2'h2) // RULE18
    else $error("Resolution code illegal.");
  a_base_fixed: assert property ((s_q.t_base == 2'h2 && s_q.res == FRS_RES_COARSE)
      |=> ramp_base_freq == FRS_B100_COARSE) // RULE16
    else $error("Fixed 100Hz base wrong.");
  a_ud_cleared: assert property ((x_is_digital && s_q.ud_mode == 2'h3 && !running)
      |=> s_q.ud == '0) // RULE17
    else $error("Up/down not cleared on stop.");
  a_bus_ready: assert property ((psel && !penable) |=> (!psel || (penable && pready))) // Local design decision: APB access phase is ready
    else $error("Access phase without ready.");

  c_switch_y: cover property (s_q.units == FRS_U_XY && asrt_sw);
  c_comb_max: cover property (comb_used && s_q.tens == 2'h2);
  c_upper_an: cover property (s_q.up_src == FRS_UP_AN1);
  c_bus_err: cover property (pslverr);
endmodule
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench for the frequency reference selector, driven over APB.
// Assumes: Zero-wait APB slave; the fixed waits follow the hand-over latencies.
// Notes: Aux range stays at 100% and relative to maximum unless a test changes it.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frs_pkg::*;
  // Bus and control inputs, all given a value at time zero.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  frs_freq_t x_in = '0, y_in = '0, run_freq = '0, pulse_upper = '0, comm_upper = '0;
  logic x_is_digital = 1'b0, running = 1'b0, freq_switch_pin = 1'b0;
  logic up_pin = 1'b0, down_pin = 1'b0;
  logic [11:0] an1 = 12'hFFF, an2 = 12'hFFF;
  logic [1:0] ramp_set_sel = 2'h0;
  // Observed outputs.
  frs_freq_t target_freq, upper_limit, ramp_base_freq;
  logic [23:0] ramp_time_cs;
  logic [1:0] freq_decimals;
  // Bookkeeping; rd and err_seen hold what the last bus cycle returned.
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err_seen;
  // Expected tables: combined results with offset 50, then switch modes per pin level.
  int comb_exp[4] = '{-32'sh96, 32'sh352, -32'sh1C2, 32'sh15E};
  int sel_exp[10] = '{32'sh12C, 32'sh12C, -32'sh96, -32'sh96, 32'sh12C, -32'sh1F4,
                      32'sh12C, -32'sh96, -32'sh1F4, -32'sh96};
  logic [2:0] up_code[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
  int up_exp[5] = '{32'sh2710, 32'sh2774, 32'sh2774, 32'shC1C, 32'shFA0};
  int tm_exp[3] = '{32'sh2710, 32'sh3E8, 32'sh64};

  // The clock toggles every 20 ns, for a period of 40 ns.
  initial begin
    forever #20 pclk = ~pclk;
  end

  frs_selector #(.AW(12)) i_frs_selector (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .x_in(x_in), .y_in(y_in), .x_is_digital(x_is_digital), .running(running),
    .run_freq(run_freq), .freq_switch_pin(freq_switch_pin), .up_pin(up_pin),
    .down_pin(down_pin), .analog_input_one(an1), .analog_input_two_or_current(an2),
    .pulse_upper(pulse_upper), .comm_upper(comm_upper), .ramp_set_sel(ramp_set_sel),
    .target_freq(target_freq), .upper_limit(upper_limit), .ramp_base_freq(ramp_base_freq),
    .ramp_time_cs(ramp_time_cs), .freq_decimals(freq_decimals)
  );

  // Compares one value; signed widening keeps negative frequencies intact.
  task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t ns %s: saw %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask

  // Four edges cover the pin synchroniser plus the output register.
  task automatic settle;
    repeat (4) @(posedge pclk);
    #1;
  endtask

  // A press is held long enough for the two-stage synchroniser to see it.
  task automatic press(input logic up);
    @(posedge pclk);
    up_pin <= up;
    down_pin <= ~up;
    repeat (4) @(posedge pclk);
    up_pin <= 1'b0;
    down_pin <= 1'b0;
    settle();
  endtask

  task automatic done(input string name);
    $display("Test %s finished, %0d mismatches so far", name, errors);
  endtask

  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs a few hundred cycles.
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors++;
      $display("[FAIL] %0t ns run did not finish in time", $time);
      complete_run();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    #1;
    check(freq_decimals, 32'h2, "resolution in reset");
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(FRS_OFS_COMBO, 32'h0, "combo reset");
    rchk(FRS_OFS_RAMP, 32'h2101, "ramp reset");
    rchk(FRS_OFS_MAXF, 32'h1388, "max freq reset");
    rchk(FRS_OFS_AUXPCT, 32'h64, "aux range reset");
    rchk(8'h2C, 32'h0, "unmapped read data");
    check(err_seen, 32'h1, "unmapped error");
    done("registers");
    // Upper limit 100.00Hz keeps every target below saturation.
    wr(FRS_OFS_UPDIG, 32'h2710);
    wr(FRS_OFS_OFFSET, 32'h32);
    @(posedge pclk);
    x_in <= 18'h0012C;
    y_in <= -18'sh001F4;
    for (int t = 0; t < 4; t++) begin
      wr(FRS_OFS_COMBO, (32'(t) << 4) | 32'h1);
      settle();
      check(target_freq, comb_exp[t], "combined");
    end
    done("combinations");
    // Every units code with the switch pin low then high; tens stays at sum.
    for (int u = 0; u < 5; u++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge pclk);
        freq_switch_pin <= s[0];
        wr(FRS_OFS_COMBO, 32'(u));
        settle();
        check(target_freq, sel_exp[u * 2 + s], "switch");
      end
    end
    rchk(FRS_OFS_TARGET, 32'h3FF6A, "target read");
    done("switching");
    // With X at half of maximum, a relative aux range halves Y.
    wr(FRS_OFS_OFFSET, 32'h0);
    @(posedge pclk);
    freq_switch_pin <= 1'b0;
    x_in <= 18'h009C4;
    y_in <= 18'h00064;
    wr(FRS_OFS_COMBO, 32'h1);
    settle();
    check(target_freq, 32'hA28, "aux relative to maximum");
    wr(FRS_OFS_COMBO, 32'h101);
    settle();
    check(target_freq, 32'h9F6, "aux relative to X");
    done("aux range");
    // The target must follow X exactly one edge later.
    wr(FRS_OFS_COMBO, 32'h0);
    settle();
    @(posedge pclk);
    x_in <= 18'h007D0;
    #1;
    check(target_freq, 32'h9C4, "target before update");
    @(posedge pclk);
    #1;
    check(target_freq, 32'h7D0, "target one edge later");
    done("latency");
    // Time unit moves the decimal point of the same stored count.
    wr(FRS_OFS_TIME0, 32'h64);
    wr(FRS_OFS_TIME0 + 8'h04, 32'h7);
    for (int u = 0; u < 3; u++) begin
      wr(FRS_OFS_RAMP, 32'h2100 | 32'(u));
      settle();
      check(ramp_time_cs, tm_exp[u], "ramp time unit");
    end
    @(posedge pclk);
    ramp_set_sel <= 2'h1;
    wr(FRS_OFS_RAMP, 32'h2101);
    settle();
    check(ramp_time_cs, 32'h46, "second time set");
    check(ramp_base_freq, 32'h1388, "base is maximum");
    wr(FRS_OFS_RAMP, 32'h2121);
    settle();
    check(ramp_base_freq, 32'h2710, "base 100Hz fine");
    wr(FRS_OFS_RAMP, 32'h1121);
    settle();
    check(ramp_base_freq, 32'h3E8, "base 100Hz coarse");
    check(freq_decimals, 32'h1, "coarse resolution");
    wr(FRS_OFS_RAMP, 32'h2111);
    settle();
    check(ramp_base_freq, 32'h7D0, "base is set freq");
    done("ramp");
    // Step by set frequency, then frozen and cleared while stopped.
    @(posedge pclk);
    x_is_digital <= 1'b1;
    running <= 1'b1;
    wr(FRS_OFS_RAMP, 32'h2101);
    press(1'b1);
    check(target_freq, 32'h7D1, "step up");
    @(posedge pclk);
    running <= 1'b0;
    wr(FRS_OFS_RAMP, 32'h2201);
    press(1'b1);
    check(target_freq, 32'h7D1, "frozen when stopped");
    wr(FRS_OFS_RAMP, 32'h2301);
    settle();
    check(target_freq, 32'h7D0, "cleared when stopped");
    @(posedge pclk);
    running <= 1'b1;
    wr(FRS_OFS_RAMP, 32'h2101);
    press(1'b0);
    check(target_freq, 32'h7CF, "step down");
    @(posedge pclk);
    run_freq <= 18'h00800;
    wr(FRS_OFS_RAMP, 32'h2001);
    press(1'b1);
    check(target_freq, 32'h801, "step from running");
    @(posedge pclk);
    x_is_digital <= 1'b0;
    done("up down");
    // Every upper-limit source; only analog and pulse take the offset.
    wr(FRS_OFS_UPOFS, 32'h64);
    @(posedge pclk);
    pulse_upper <= 18'h00BB8;
    comm_upper <= 18'h00FA0;
    for (int i = 0; i < 5; i++) begin
      wr(FRS_OFS_UPCFG, 32'(up_code[i]));
      settle();
      check(upper_limit, up_exp[i], "upper source");
    end
    @(posedge pclk);
    an1 <= 12'h000;
    wr(FRS_OFS_UPCFG, 32'h1);
    settle();
    check(upper_limit, 32'h64, "analog zero plus offset");
    done("upper limit");
    // Coarse resolution caps at 3200.0Hz; other resolution codes are ignored.
    wr(FRS_OFS_UPCFG, 32'h0);
    wr(FRS_OFS_UPDIG, 32'h9C40);
    wr(FRS_OFS_RAMP, 32'h1101);
    @(posedge pclk);
    x_in <= 18'h088B8;
    settle();
    check(upper_limit, 32'h7D00, "coarse upper cap");
    check(target_freq, 32'h7D00, "coarse target cap");
    wr(FRS_OFS_RAMP, 32'h3101);
    settle();
    check(freq_decimals, 32'h1, "bad resolution ignored");
    done("resolution");
    complete_run();
  end
endmodule
`default_nettype wire
